// *** rtl/p4cs_consts.vh ***
// constants for the four-pin strobe port: register addresses, fields, reset values
`ifndef P4CS_CONSTS_VH
`define P4CS_CONSTS_VH

// ==================================================
// register addresses
`define P4CS_ADDR_POLARITY   8'hAE
`define P4CS_ADDR_FUNC_LOW   8'hC2
`define P4CS_ADDR_FUNC_HIGH  8'hC3
`define P4CS_ADDR_DATA       8'hD8
`define P4CS_ADDR_P0_LOW     8'h84
`define P4CS_ADDR_P0_HIGH    8'h85
`define P4CS_ADDR_P1_LOW     8'h94
`define P4CS_ADDR_P1_HIGH    8'h95
`define P4CS_ADDR_P2_LOW     8'hAC
`define P4CS_ADDR_P2_HIGH    8'hAD
`define P4CS_ADDR_P3_LOW     8'hB4
`define P4CS_ADDR_P3_HIGH    8'hB5

// ==================================================
// function and compare-length encodings
`define P4CS_FUNC_GPIO       2'h0
`define P4CS_FUNC_READ       2'h1
`define P4CS_FUNC_WRITE      2'h2
`define P4CS_FUNC_BOTH       2'h3
`define P4CS_CMP_FULL        2'h0
`define P4CS_CMP_15          2'h1
`define P4CS_CMP_14          2'h2
`define P4CS_CMP_8           2'h3

// ==================================================
// field positions and reset values
`define P4CS_POL_LSB         4
`define P4CS_POL_WMASK       8'hF0
`define P4CS_POL_RMASK       8'hFC
`define P4CS_DATA_MASK       8'h0F
`define P4CS_RST_ZERO        8'h00
`define P4CS_RST_DATA        4'hF

`endif

// *** rtl/p4cs_match.v ***
// address comparator for one strobe pin
`timescale 1ns/100ps
module p4cs_match (
    input  wire [15:0] BUS_ADDR,
    input  wire [15:0] BASE,
    input  wire [1:0]  CMP_LEN,
    output reg         HIT
);
`include "p4cs_consts.vh"
    reg [15:0] mask;

    // ==================================================
    // masked compare
    always @* begin
        case (CMP_LEN)
            `P4CS_CMP_FULL: mask = 16'hFFFF;
            `P4CS_CMP_15:   mask = 16'hFFFE;
            `P4CS_CMP_14:   mask = 16'hFFFC;
            `P4CS_CMP_8:    mask = 16'hFF00;
            default:        mask = 16'hFFFF;
        endcase
        HIT = ((BUS_ADDR & mask) == (BASE & mask));
    end
endmodule // p4cs_match

// *** rtl/p4cs_port.v ***
// four-pin port: general I/O bits or address-decoded chip-select strobes
`timescale 1ns/100ps
// Overview of operation
// - function 00: pin is a quasi-bidirectional general I/O bit
// - function 01: strobe during matching external reads only
// - function 10: strobe during matching external writes only
// - function 11: strobe during matching reads and writes
// - compare length 00: all sixteen address bits compared
// - compare length 01: bits 15..1 compared, bit 0 ignored
// - compare length 10: bits 15..2 compared, low two ignored
// - compare length 11: bits 15..8 compared, low byte ignored
// - high control register: pin3 function 7:6, length 5:4; pin2 3:2, 1:0
// - low control register: pin1 function 7:6, length 5:4; pin0 3:2, 1:0
// - polarity bits 7..4 for pins 3..0; 1 active high, 0 active low
// - each pin has a high and a low base address byte
// - data bits 3..0 drive general I/O pins; bits 7..4 reserved
// - polarity resets to 0, giving an active-low strobe
// - matching external data write pulses a write-strobe pin
// - strobe coincides with the bus read or write strobe
module p4cs_port (
    input  wire        CLK,
    input  wire        RESET_N,
    input  wire        SFR_WR,
    input  wire        SFR_RD,
    input  wire [7:0]  SFR_ADDR,
    input  wire [7:0]  SFR_WDATA,
    output reg  [7:0]  SFR_RDATA,
    input  wire [15:0] EXT_ADDR,
    input  wire        EXT_RD_N,
    input  wire        EXT_WR_N,
    input  wire [3:0]  PIN_IN,
    output wire [3:0]  PIN_OUT,
    output wire [3:0]  PIN_OE_N
);
`include "p4cs_consts.vh"

    // ==================================================
    // reset release
    reg        rst_meta;
    reg        rst_sync;
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ==================================================
    // registers
    reg [7:0]  polarity;
    reg [7:0]  func_low;
    reg [7:0]  func_high;
    reg [3:0]  port_data;
    reg [7:0]  base_low  [0:3];
    reg [7:0]  base_high [0:3];
    integer    i;
    // separate loop index so the comb loop shares no variable with the clocked reset loop
    integer    j;

    // pin index of a base-address register, or 4 when none
    function [2:0] base_index;
        input [7:0] a;
        begin
            case (a)
                `P4CS_ADDR_P0_LOW, `P4CS_ADDR_P0_HIGH: base_index = 3'h0;
                `P4CS_ADDR_P1_LOW, `P4CS_ADDR_P1_HIGH: base_index = 3'h1;
                `P4CS_ADDR_P2_LOW, `P4CS_ADDR_P2_HIGH: base_index = 3'h2;
                `P4CS_ADDR_P3_LOW, `P4CS_ADDR_P3_HIGH: base_index = 3'h3;
                default:                               base_index = 3'h4;
            endcase
        end
    endfunction

    // high byte registers sit at odd addresses
    function is_high;
        input [7:0] a;
        begin
            is_high = a[0];
        end
    endfunction

    wire [2:0] wr_idx = base_index(SFR_ADDR);
    wire [2:0] rd_idx = base_index(SFR_ADDR);

    always @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            polarity  <= `P4CS_RST_ZERO;
            func_low  <= `P4CS_RST_ZERO;
            func_high <= `P4CS_RST_ZERO;
            port_data <= `P4CS_RST_DATA;
            for (i = 0; i < 4; i = i + 1) begin
                base_low[i]  <= `P4CS_RST_ZERO;
                base_high[i] <= `P4CS_RST_ZERO;
            end
        end else if (SFR_WR) begin
            case (SFR_ADDR)
                `P4CS_ADDR_POLARITY:  polarity  <= SFR_WDATA & `P4CS_POL_WMASK;
                `P4CS_ADDR_FUNC_LOW:  func_low  <= SFR_WDATA;
                `P4CS_ADDR_FUNC_HIGH: func_high <= SFR_WDATA;
                `P4CS_ADDR_DATA:      port_data <= SFR_WDATA[3:0];
                default: begin
                    if (wr_idx != 3'h4) begin
                        if (is_high(SFR_ADDR))
                            base_high[wr_idx[1:0]] <= SFR_WDATA;
                        else
                            base_low[wr_idx[1:0]]  <= SFR_WDATA;
                    end
                end
            endcase
        end
    end

    // ==================================================
    // register read; the data register returns pin levels like a standard port
    always @(posedge CLK or negedge rst_sync) begin
        if (!rst_sync) begin
            SFR_RDATA <= `P4CS_RST_ZERO;
        end else if (SFR_RD) begin
            case (SFR_ADDR)
                `P4CS_ADDR_POLARITY:  SFR_RDATA <= polarity & `P4CS_POL_RMASK;
                `P4CS_ADDR_FUNC_LOW:  SFR_RDATA <= func_low;
                `P4CS_ADDR_FUNC_HIGH: SFR_RDATA <= func_high;
                `P4CS_ADDR_DATA:      SFR_RDATA <= {4'h0, PIN_IN} & `P4CS_DATA_MASK;
                default: begin
                    if (rd_idx == 3'h4)
                        SFR_RDATA <= `P4CS_RST_ZERO;
                    else if (is_high(SFR_ADDR))
                        SFR_RDATA <= base_high[rd_idx[1:0]];
                    else
                        SFR_RDATA <= base_low[rd_idx[1:0]];
                end
            endcase
        end
    end

    // ==================================================
    // per-pin fields
    wire [1:0] func [0:3];
    wire [1:0] clen [0:3];
    assign func[0] = func_low[3:2];
    assign clen[0] = func_low[1:0];
    assign func[1] = func_low[7:6];
    assign clen[1] = func_low[5:4];
    assign func[2] = func_high[3:2];
    assign clen[2] = func_high[1:0];
    assign func[3] = func_high[7:6];
    assign clen[3] = func_high[5:4];

    // ==================================================
    // strobe generation; combinational so it tracks the bus strobes with no lag
    wire [3:0] hit;
    reg  [3:0] active;
    reg  [3:0] pin_drive;
    reg  [3:0] pin_oe_n;
    wire       rd_cycle = ~EXT_RD_N;
    wire       wr_cycle = ~EXT_WR_N;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pin
            p4cs_match u_match (
                .BUS_ADDR (EXT_ADDR),
                .BASE     ({base_high[g], base_low[g]}),
                .CMP_LEN  (clen[g]),
                .HIT      (hit[g])
            );
        end
    endgenerate

    always @* begin
        active    = 4'h0;
        pin_drive = 4'h0;
        pin_oe_n  = 4'h0;
        for (j = 0; j < 4; j = j + 1) begin
            case (func[j])
                `P4CS_FUNC_READ:  active[j] = hit[j] & rd_cycle;
                `P4CS_FUNC_WRITE: active[j] = hit[j] & wr_cycle;
                `P4CS_FUNC_BOTH:  active[j] = hit[j] & (rd_cycle | wr_cycle);
                default:          active[j] = 1'b0;
            endcase
            if (func[j] == `P4CS_FUNC_GPIO) begin
                // quasi-bidirectional: drive low actively, release for a one
                pin_drive[j] = port_data[j];
                pin_oe_n[j]  = port_data[j];
            end else begin
                // data bit ignored; inactive level is the inverse of polarity
                pin_drive[j] = ~(active[j] ^ polarity[`P4CS_POL_LSB + j]);
                pin_oe_n[j]  = 1'b0;
            end
        end
    end

    assign PIN_OUT  = pin_drive;
    assign PIN_OE_N = pin_oe_n;

endmodule // p4cs_port

// *** dv/p4cs_periph.sv ***
// partner model: peripheral side of the four port pins
`timescale 1ns/100ps
module p4cs_periph (
    input  wire [3:0] pin_out,
    input  wire [3:0] pin_oe_n,
    input  wire [3:0] pull_low,
    output wire [3:0] pin_in
);
    // pull-up holds a released pin high; a peripheral may sink it
    assign pin_in = ~pull_low & (pin_oe_n | pin_out);
endmodule // p4cs_periph

// *** dv/p4cs_port_chk.sv ***
// checker for the four-pin strobe port
`timescale 1ns/100ps
module p4cs_port_chk (
    input wire        CLK,
    input wire        RESET_N,
    input wire        SFR_WR,
    input wire        SFR_RD,
    input wire [7:0]  SFR_ADDR,
    input wire [7:0]  SFR_WDATA,
    input wire [7:0]  SFR_RDATA,
    input wire [15:0] EXT_ADDR,
    input wire        EXT_RD_N,
    input wire        EXT_WR_N,
    input wire [3:0]  PIN_IN,
    input wire [3:0]  PIN_OUT,
    input wire [3:0]  PIN_OE_N
);
    // ==========
    // shadow registers
    reg  [7:0] fl, fh, pol;
    reg  [3:0] dat;
    wire [1:0] f0 = fl[3:2];
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            {fl, fh, pol, dat} <= 28'h000000F;
        end else if (SFR_WR) begin
            case (SFR_ADDR)
                8'hC2: fl <= SFR_WDATA;
                8'hC3: fh <= SFR_WDATA;
                8'hAE: pol <= SFR_WDATA & 8'hF0;
                8'hD8: dat <= SFR_WDATA[3:0];
                default: ;
            endcase
        end
    end
    // ==========
    // assertions
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_rd(a);
        SFR_RD && SFR_ADDR == a;
    endsequence
    a_low_readback: assert property (s_rd(8'hC2) |=> SFR_RDATA == $past(fl)) else $error("ctl low");
    a_high_readback: assert property (s_rd(8'hC3) |=> SFR_RDATA == $past(fh)) else $error("ctl high");
    a_pol_readback: assert property (s_rd(8'hAE) |=> SFR_RDATA == $past(pol)) else $error("polarity");
    a_data_readback: assert property (s_rd(8'hD8) |=> SFR_RDATA == {4'h0, $past(PIN_IN)}) else $error("data");
    a_gpio_drive: assert property (fh[7:6] == 2'h0 |-> PIN_OE_N[3] == dat[3]) else $error("gpio");
    a_strobe_owns: assert property (f0 != 2'h0 |-> !PIN_OE_N[0]) else $error("strobe enable");
    a_strobe_idle: assert property (f0 != 2'h0 && EXT_RD_N && EXT_WR_N |-> PIN_OUT[0] == !pol[4]) else $error("idle");
    a_read_only: assert property (f0 == 2'h1 && EXT_RD_N |-> PIN_OUT[0] == !pol[4]) else $error("rd only");
    a_write_only: assert property (f0 == 2'h2 && EXT_WR_N |-> PIN_OUT[0] == !pol[4]) else $error("wr only");
endmodule // p4cs_port_chk
bind p4cs_port p4cs_port_chk p4cs_port_chk_inst (.CLK(CLK), .RESET_N(RESET_N), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .EXT_ADDR(EXT_ADDR), .EXT_RD_N(EXT_RD_N),
    .EXT_WR_N(EXT_WR_N), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N));

// *** dv/testbench.sv ***
// testbench for the four-pin strobe port
`timescale 1ns/100ps
module testbench;
    reg         CLK = 1'h0, RESET_N = 1'h0, wr = 1'h0, rd = 1'h0, rdn = 1'h1, wrn = 1'h1, p;
    reg  [7:0]  ad = 8'h00, wd = 8'h00, q, la;
    reg  [15:0] ea = 16'h0000, b;
    reg  [3:0]  pl = 4'h0;
    wire [7:0]  rdat;
    wire [3:0]  po, poe, pin;
    integer     failures = 0, check_count = 0, i, f, c, k;
    p4cs_port p4cs_port_inst (.CLK(CLK), .RESET_N(RESET_N), .SFR_WR(wr), .SFR_RD(rd), .SFR_ADDR(ad), .SFR_WDATA(wd),
        .SFR_RDATA(rdat), .EXT_ADDR(ea), .EXT_RD_N(rdn), .EXT_WR_N(wrn), .PIN_IN(pin), .PIN_OUT(po), .PIN_OE_N(poe));
    p4cs_periph p4cs_periph_inst (.pin_out(po), .pin_oe_n(poe), .pull_low(pl), .pin_in(pin));
    initial forever #5 CLK = ~CLK;
    // ==========
    // helpers
    function [15:0] msk(input [1:0] c);
        msk = c == 2'h0 ? 16'hFFFF : c == 2'h1 ? 16'hFFFE : c == 2'h2 ? 16'hFFFC : 16'hFF00;
    endfunction
    function exp_pin(input [1:0] f, input [1:0] c, input p, input [15:0] b, input [15:0] a, input r, input w);
        exp_pin = ((((a ^ b) & msk(c)) == 16'h0000) && ((f[0] && !r) || (f[1] && !w))) ^ !p;
    endfunction
    task chk(input [15:0] g, input [15:0] e);
        check_count = check_count + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr8(input [7:0] a, input [7:0] d);
        @(posedge CLK); wr <= 1'h1; ad <= a; wd <= d;
        @(posedge CLK); wr <= 1'h0;
    endtask
    task rd8(input [7:0] a);
        @(posedge CLK); rd <= 1'h1; ad <= a;
        @(posedge CLK); rd <= 1'h0;
        @(negedge CLK); q = rdat;
    endtask
    task print_verdict;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========
    // tests
    initial begin
        q = $urandom(27);
        repeat (5) @(posedge CLK);
        RESET_N <= 1'h1;
        repeat (3) @(posedge CLK);
        rd8(8'hAE); chk(q, 8'h00);
        rd8(8'hC3); chk(q, 8'h00);
        rd8(8'hD8); chk(q, 8'h0F);
        chk(poe, 4'hF);
        $display("test reset done");
        repeat (8) begin
            b = $urandom;
            pl <= b[7:4];
            wr8(8'hD8, b[7:0]);
            @(negedge CLK); chk(poe, b[3:0]);
            rd8(8'hD8); chk(q, {4'h0, b[3:0] & ~b[7:4]});
        end
        pl <= 4'h0;
        $display("test gpio done");
        wr8(8'hD8, 8'h00);
        // data bits at zero so a leaking data path would pull strobes low
        for (i = 0; i < 4; i = i + 1) for (f = 1; f < 4; f = f + 1) for (c = 0; c < 4; c = c + 1) begin
            b = $urandom;
            p = $urandom;
            la = i == 0 ? 8'h84 : i == 1 ? 8'h94 : i == 2 ? 8'hAC : 8'hB4;
            wr8(la, b[7:0]);
            wr8(la + 8'h01, b[15:8]);
            wr8(i < 2 ? 8'hC2 : 8'hC3, {4'h0, f[1:0], c[1:0]} << (4 * (i % 2)));
            wr8(8'hAE, (8'h10 << i) & {8{p}});
            for (k = 0; k < 4; k = k + 1) begin
                @(posedge CLK);
                ea <= b ^ (k[1] ? $urandom : $urandom & ~msk(c));
                rdn <= k[0];
                wrn <= ~k[0];
                @(negedge CLK); chk(pin[i], exp_pin(f, c, p, b, ea, rdn, wrn));
                chk(poe[i], 1'h0);
                @(posedge CLK); rdn <= 1'h1; wrn <= 1'h1;
                @(negedge CLK); chk(pin[i], !p);
            end
        end
        $display("test strobe done");
        print_verdict;
    end
    initial begin
        #200000;
        failures = failures + 1;
        print_verdict;
    end
endmodule // testbench
